// ### iop_pkg.sv
// Package with register map, field layouts and reset values of the eight-pin port block.
package iop_pkg;

	localparam int NUM_PINS = 8;
	localparam int NUM_OE_LINES = 16;

	// Register byte offsets on the register bus.
	localparam logic [7:0] OFS_DATA = 8'h00;
	localparam logic [7:0] OFS_DM0 = 8'h04;
	localparam logic [7:0] OFS_DM1 = 8'h08;
	localparam logic [7:0] OFS_DM2 = 8'h0c;
	localparam logic [7:0] OFS_BYPASS = 8'h10;
	localparam logic [7:0] OFS_SLEW = 8'h14;
	localparam logic [7:0] OFS_INBUF_DIS = 8'h18;
	localparam logic [7:0] OFS_BIDIR_EN = 8'h1c;
	localparam logic [7:0] OFS_PIN_STATE = 8'h20;
	localparam logic [7:0] OFS_PORT_CTL = 8'h24;
	localparam logic [7:0] OFS_INT_STAT = 8'h28;
	localparam logic [7:0] OFS_INT_TYPE = 8'h2c;
	localparam logic [7:0] OFS_SIO_CFG = 8'h30;
	localparam logic [7:0] OFS_OE_SEL_LO = 8'h34;
	localparam logic [7:0] OFS_OE_SEL_HI = 8'h38;
	localparam logic [7:0] OFS_PIN_FORM = 8'h40;
	localparam logic [7:0] OFS_PIN_FORM_END = 8'h5c;

	// Pin-form register bit positions.
	localparam int PF_DATA = 0;
	localparam int PF_DM_LSB = 1;
	localparam int PF_STATE = 4;
	localparam int PF_SLEW = 5;
	localparam int PF_BYPASS = 6;
	localparam int PF_BIDIR = 7;

	// Port control bit positions.
	localparam int CTL_LVTTL = 0;
	localparam int CTL_HYST = 1;
	localparam int CTL_THR_LSB = 2;

	// Drive modes.
	localparam logic [2:0] DM_HIZ_ANALOG = 3'h0;
	localparam logic [2:0] DM_HIZ_DIGITAL = 3'h1;
	localparam logic [2:0] DM_RES_UP = 3'h2;
	localparam logic [2:0] DM_RES_DOWN = 3'h3;
	localparam logic [2:0] DM_OD_LOW = 3'h4;
	localparam logic [2:0] DM_OD_HIGH = 3'h5;
	localparam logic [2:0] DM_STRONG = 3'h6;
	localparam logic [2:0] DM_RES_BOTH = 3'h7;

	// Edge interrupt selections, two bits per pin.
	localparam logic [1:0] IT_NONE = 2'h0;
	localparam logic [1:0] IT_RISE = 2'h1;
	localparam logic [1:0] IT_FALL = 2'h2;
	localparam logic [1:0] IT_BOTH = 2'h3;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [7:0] RST_BYTE = 8'h00;

endpackage : iop_pkg

// ### iop_port.sv
// Eight-pin port: drive modes, bidirectional control, edge interrupts and register slave.
`timescale 1ns/1ps

// Behaviour
// - Each pin picks one of eight drive modes with three per-pin mode bits.
// - Driven value comes from the data bit, or the system signal when bypassed.
// - After reset every pin is analog high impedance, no driver, no input.
// - High impedance digital: driver off, input buffer on.
// - Resistive up/down: one state through resistor, other strong, input readable.
// - Resistive modes are unavailable on special pins in regulated output level.
// - Open drain modes: float one state, drive the other strongly, input readable.
// - Strong mode drives both states; reading input there is discouraged.
// - Combined resistive mode always drives through a resistor, up or down.
// - Port-form registers map each bit to the matching pin.
// - Per-pin register gathers eight port bits and stays consistent with port form.
// - Bidirectional pins switch between digital high-Z input and mode by enable.
// - Up to 16 output-enable lines routed, each to one or more pins.
// - Per-pin slew choice acts in strong and open drain modes only.
// - All eight pins feed one port interrupt unit with its own request.
// - Each pin selects rising, falling, both edges or no interrupt.
// - A configured edge sets the pin's status bit and raises the request.
// - Edge detection keeps working during sleep so a pin can wake the chip.
// - No level-sensitive pin interrupts are provided.
// - Port selects CMOS or LVTTL input thresholds for all its pins.
// - Each pin's input buffer can be disabled in any drive mode.
// - Each special pin selects supply-level or regulated high output.
// - All special pins share one port threshold: 0.5 or 0.4 supply, half or full reference.
// - Hysteresis can be enabled on special pin input buffers.
module iop_port
	import iop_pkg::*;
#(
	parameter int PINS = NUM_PINS,
	parameter int OE_LINES = NUM_OE_LINES,
	parameter bit SPECIAL_PINS = 1'b1
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] pin_in,
	output logic [7:0] pin_out,
	output logic [7:0] pin_strong_oe_n,
	output logic [7:0] pin_res_up,
	output logic [7:0] pin_res_down,
	output logic [7:0] pin_slow_slew,
	output logic [7:0] pin_inbuf_en,
	output logic [7:0] pin_vhigh_regulated,
	output logic pin_lvttl,
	output logic pin_hyst_en,
	output logic [1:0] pin_threshold_sel,
	input wire logic [7:0] sys_out,
	input wire logic [15:0] aux_oe,
	output logic [7:0] sys_in,
	output logic port_irq
);

	typedef struct packed {
		logic [7:0] data;
		logic [7:0] dm0;
		logic [7:0] dm1;
		logic [7:0] dm2;
		logic [7:0] bypass;
		logic [7:0] slew;
		logic [7:0] inbuf_dis;
		logic [7:0] bidir;
		logic [3:0] ctl;
		logic [7:0] int_stat;
		logic [15:0] int_type;
		logic [7:0] sio_reg;
		logic [31:0] oe_sel;
		logic [7:0] sync1;
		logic [7:0] sync2;
		logic [7:0] sync3;
		logic [7:0] pin_level;
		logic aw_held;
		logic [7:0] aw_addr;
		logic w_held;
		logic [31:0] w_data;
		logic [3:0] w_strb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [31:0] rdata;
		logic [1:0] rresp;
	} iop_state_type;

	iop_state_type st;
	iop_state_type next_st;

	logic [7:0] drive_value;
	logic [2:0] eff_mode [8];
	logic [7:0] oe_line;
	logic [7:0] edge_hit;

	function automatic logic [7:0] merge_byte(input logic [7:0] old_v, input logic [7:0] new_v,
			input logic en);
		merge_byte = en ? new_v : old_v;
	endfunction : merge_byte

	function automatic logic [2:0] pin_mode(input iop_state_type s, input int p);
		pin_mode = {s.dm2[p], s.dm1[p], s.dm0[p]};
	endfunction : pin_mode

	// Per-pin output path.
	always_comb begin
		for (int p = 0; p < 8; p++) begin
			logic [2:0] m;
			logic resistive;
			m = pin_mode(st, p);
			resistive = 1'b0;
			oe_line[p] = aux_oe[st.oe_sel[4*p +: 4]];
			if (st.bidir[p] && !oe_line[p]) begin
				m = DM_HIZ_DIGITAL;
			end
			resistive = (m == DM_RES_UP) || (m == DM_RES_DOWN) || (m == DM_RES_BOTH);
			if (SPECIAL_PINS && st.sio_reg[p] && resistive) begin
				m = DM_HIZ_DIGITAL;
			end
			eff_mode[p] = m;
			drive_value[p] = st.bypass[p] ? sys_out[p] : st.data[p];
			pin_out[p] = drive_value[p];
			pin_strong_oe_n[p] = 1'b1;
			pin_res_up[p] = 1'b0;
			pin_res_down[p] = 1'b0;
			case (m)
				DM_RES_UP: begin
					pin_res_up[p] = drive_value[p];
					pin_strong_oe_n[p] = drive_value[p];
				end
				DM_RES_DOWN: begin
					pin_res_down[p] = !drive_value[p];
					pin_strong_oe_n[p] = !drive_value[p];
				end
				DM_OD_LOW: pin_strong_oe_n[p] = drive_value[p];
				DM_OD_HIGH: pin_strong_oe_n[p] = !drive_value[p];
				DM_STRONG: pin_strong_oe_n[p] = 1'b0;
				DM_RES_BOTH: begin
					pin_res_up[p] = drive_value[p];
					pin_res_down[p] = !drive_value[p];
				end
				default: pin_strong_oe_n[p] = 1'b1;
			endcase
			pin_slow_slew[p] = st.slew[p] && !resistive && (m >= DM_OD_LOW)
				&& (m != DM_RES_BOTH);
			pin_inbuf_en[p] = (m != DM_HIZ_ANALOG) && !st.inbuf_dis[p];
			pin_vhigh_regulated[p] = SPECIAL_PINS && st.sio_reg[p];
		end
	end

	assign pin_lvttl = st.ctl[CTL_LVTTL];
	assign pin_hyst_en = SPECIAL_PINS && st.ctl[CTL_HYST];
	assign pin_threshold_sel = st.ctl[CTL_THR_LSB +: 2];
	assign sys_in = st.pin_level;

	// Edge events from the filtered pin level; no clock gating, so sleep does not stop them.
	always_comb begin
		for (int p = 0; p < 8; p++) begin
			logic rise;
			logic fall;
			logic [1:0] t;
			rise = (st.sync2[p] == st.sync3[p]) && st.sync3[p] && !st.pin_level[p];
			fall = (st.sync2[p] == st.sync3[p]) && !st.sync3[p] && st.pin_level[p];
			t = st.int_type[2*p +: 2];
			edge_hit[p] = ((t == IT_RISE || t == IT_BOTH) && rise)
				|| ((t == IT_FALL || t == IT_BOTH) && fall);
		end
	end

	assign port_irq = |st.int_stat;

	assign s_axi_awready = !st.aw_held && !st.bvalid;
	assign s_axi_wready = !st.w_held && !st.bvalid;
	assign s_axi_arready = !st.rvalid;
	assign s_axi_bvalid = st.bvalid;
	assign s_axi_bresp = st.bresp;
	assign s_axi_rvalid = st.rvalid;
	assign s_axi_rdata = st.rdata;
	assign s_axi_rresp = st.rresp;

	always_comb begin
		logic do_wr;
		logic [7:0] wa;
		logic [7:0] wb;
		logic we;
		logic [7:0] ra;
		logic [31:0] rd;
		logic ok;
		logic [7:0] clr;
		int idx;
		next_st = st;
		do_wr = 1'b0;
		wa = 8'h00;
		wb = 8'h00;
		we = 1'b0;
		ra = 8'h00;
		rd = 32'h0000_0000;
		ok = 1'b1;
		clr = 8'h00;
		idx = 0;
		// Pin inputs: three stages, level updates once the last two agree.
		next_st.sync1 = pin_in & pin_inbuf_en;
		next_st.sync2 = st.sync1;
		next_st.sync3 = st.sync2;
		for (int p = 0; p < 8; p++) begin
			if (st.sync2[p] == st.sync3[p]) begin
				next_st.pin_level[p] = st.sync3[p];
			end
		end
		if (s_axi_awvalid && s_axi_awready) begin
			next_st.aw_held = 1'b1;
			next_st.aw_addr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_st.w_held = 1'b1;
			next_st.w_data = s_axi_wdata;
			next_st.w_strb = s_axi_wstrb;
		end
		if (st.aw_held && st.w_held) begin
			do_wr = 1'b1;
			wa = st.aw_addr;
			wb = st.w_data[7:0];
			we = st.w_strb[0];
			next_st.aw_held = 1'b0;
			next_st.w_held = 1'b0;
			next_st.bvalid = 1'b1;
			next_st.bresp = RESP_OKAY;
			case ({wa[7:2], 2'b00})
				OFS_DATA: next_st.data = merge_byte(st.data, wb, we);
				OFS_DM0: next_st.dm0 = merge_byte(st.dm0, wb, we);
				OFS_DM1: next_st.dm1 = merge_byte(st.dm1, wb, we);
				OFS_DM2: next_st.dm2 = merge_byte(st.dm2, wb, we);
				OFS_BYPASS: next_st.bypass = merge_byte(st.bypass, wb, we);
				OFS_SLEW: next_st.slew = merge_byte(st.slew, wb, we);
				OFS_INBUF_DIS: next_st.inbuf_dis = merge_byte(st.inbuf_dis, wb, we);
				OFS_BIDIR_EN: next_st.bidir = merge_byte(st.bidir, wb, we);
				OFS_PIN_STATE: ;
				OFS_PORT_CTL: if (we) next_st.ctl = wb[3:0];
				OFS_INT_STAT: if (we) clr = wb;
				OFS_INT_TYPE: begin
					if (st.w_strb[0]) next_st.int_type[7:0] = st.w_data[7:0];
					if (st.w_strb[1]) next_st.int_type[15:8] = st.w_data[15:8];
				end
				OFS_SIO_CFG: next_st.sio_reg = merge_byte(st.sio_reg, wb, we);
				OFS_OE_SEL_LO: begin
					for (int b = 0; b < 4; b++) begin
						if (st.w_strb[b]) next_st.oe_sel[8*b +: 8] = st.w_data[8*b +: 8];
					end
				end
				OFS_OE_SEL_HI: ;
				default: begin
					if (wa >= OFS_PIN_FORM && wa <= OFS_PIN_FORM_END) begin
						idx = int'(wa[4:2]);
						if (we) begin
							next_st.data[idx] = wb[PF_DATA];
							next_st.dm0[idx] = wb[PF_DM_LSB];
							next_st.dm1[idx] = wb[PF_DM_LSB + 1];
							next_st.dm2[idx] = wb[PF_DM_LSB + 2];
							next_st.slew[idx] = wb[PF_SLEW];
							next_st.bypass[idx] = wb[PF_BYPASS];
							next_st.bidir[idx] = wb[PF_BIDIR];
						end
					end else begin
						next_st.bresp = RESP_SLVERR;
					end
				end
			endcase
		end
		if (st.bvalid && s_axi_bready) begin
			next_st.bvalid = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			ra = s_axi_araddr;
			case ({ra[7:2], 2'b00})
				OFS_DATA: rd = {24'h000000, st.data};
				OFS_DM0: rd = {24'h000000, st.dm0};
				OFS_DM1: rd = {24'h000000, st.dm1};
				OFS_DM2: rd = {24'h000000, st.dm2};
				OFS_BYPASS: rd = {24'h000000, st.bypass};
				OFS_SLEW: rd = {24'h000000, st.slew};
				OFS_INBUF_DIS: rd = {24'h000000, st.inbuf_dis};
				OFS_BIDIR_EN: rd = {24'h000000, st.bidir};
				OFS_PIN_STATE: rd = {24'h000000, st.pin_level};
				OFS_PORT_CTL: rd = {28'h0000000, st.ctl};
				OFS_INT_STAT: begin
					rd = {24'h000000, st.int_stat};
					clr = clr | st.int_stat;
				end
				OFS_INT_TYPE: rd = {16'h0000, st.int_type};
				OFS_SIO_CFG: rd = {24'h000000, st.sio_reg};
				OFS_OE_SEL_LO: rd = st.oe_sel;
				OFS_OE_SEL_HI: rd = 32'h0000_0000;
				default: begin
					if (ra >= OFS_PIN_FORM && ra <= OFS_PIN_FORM_END) begin
						idx = int'(ra[4:2]);
						rd = {24'h000000, st.bidir[idx], st.bypass[idx], st.slew[idx],
							st.pin_level[idx], st.dm2[idx], st.dm1[idx], st.dm0[idx],
							st.data[idx]};
					end else begin
						ok = 1'b0;
					end
				end
			endcase
			next_st.rvalid = 1'b1;
			next_st.rdata = rd;
			next_st.rresp = ok ? RESP_OKAY : RESP_SLVERR;
		end else if (st.rvalid && s_axi_rready) begin
			next_st.rvalid = 1'b0;
		end
		// A new edge wins over a clear in the same cycle.
		next_st.int_stat = (st.int_stat & ~clr) | edge_hit;
		if (!do_wr) begin
			wb = 8'h00;
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= '0;
		end else begin
			st <= next_st;
		end
	end

	chk_reset_analog: assert property (@(posedge aclk)
		!aresetn |=> pin_inbuf_en == 8'h00 && pin_strong_oe_n == 8'hff)
		else $error("pins not analog after reset");
	chk_edge_sets: assert property (@(posedge aclk) disable iff (!aresetn)
		edge_hit[0] |=> st.int_stat[0]) else $error("edge did not set status");
	// Status must survive every cycle that carries neither an accepted read of any register nor held write data.
	chk_irq_follow: assert property (@(posedge aclk) disable iff (!aresetn)
		st.int_stat[0] && !st.w_held && !(s_axi_arvalid && s_axi_arready)
		|=> st.int_stat[0] && port_irq) else $error("status bit lost");
	chk_strong_drive: assert property (@(posedge aclk) disable iff (!aresetn)
		eff_mode[0] == DM_STRONG |-> !pin_strong_oe_n[0]) else $error("strong off");
	chk_od_low: assert property (@(posedge aclk) disable iff (!aresetn)
		eff_mode[1] == DM_OD_LOW |-> pin_strong_oe_n[1] == drive_value[1])
		else $error("open drain wrong");
	chk_res_up: assert property (@(posedge aclk) disable iff (!aresetn)
		eff_mode[1] == DM_RES_UP |-> !pin_res_down[1] && pin_res_up[1] == drive_value[1]
		&& pin_strong_oe_n[1] == drive_value[1]) else $error("pull-up mode wrong");
	chk_hiz_digital: assert property (@(posedge aclk) disable iff (!aresetn)
		eff_mode[2] == DM_HIZ_DIGITAL |-> pin_strong_oe_n[2] && !pin_res_up[2]
		&& !pin_res_down[2] && pin_inbuf_en[2] == !st.inbuf_dis[2])
		else $error("digital high impedance wrong");
	chk_res_both: assert property (@(posedge aclk) disable iff (!aresetn)
		eff_mode[7] == DM_RES_BOTH |-> pin_strong_oe_n[7] && pin_res_up[7] == drive_value[7]
		&& pin_res_down[7] == !drive_value[7]) else $error("combined pull wrong");
	chk_bidir_off: assert property (@(posedge aclk) disable iff (!aresetn)
		(st.bidir & ~oe_line) != 8'h00 |-> ((st.bidir & ~oe_line)
		& (~pin_strong_oe_n | pin_res_up | pin_res_down)) == 8'h00)
		else $error("bidir drives");
	chk_sio_nores: assert property (@(posedge aclk) disable iff (!aresetn)
		SPECIAL_PINS && st.sio_reg != 8'h00
		|-> (st.sio_reg & (pin_res_up | pin_res_down)) == 8'h00)
		else $error("resistive in regulated");
	chk_slew_res: assert property (@(posedge aclk) disable iff (!aresetn)
		eff_mode[4] == DM_RES_BOTH |-> !pin_slow_slew[4]) else $error("slew in res");
	chk_bypass_src: assert property (@(posedge aclk) disable iff (!aresetn)
		st.bypass != 8'h00 |-> ((pin_out ^ sys_out) & st.bypass) == 8'h00)
		else $error("bypass ignored");
	chk_inbuf_dis: assert property (@(posedge aclk) disable iff (!aresetn)
		st.inbuf_dis != 8'h00 |-> (st.inbuf_dis & pin_inbuf_en) == 8'h00)
		else $error("buffer not off");
	cov_irq: cover property (@(posedge aclk) disable iff (!aresetn) $rose(port_irq));
	cov_write: cover property (@(posedge aclk) disable iff (!aresetn) st.bvalid && s_axi_bready);
	cov_read: cover property (@(posedge aclk) disable iff (!aresetn) st.rvalid && s_axi_rready);
	cov_bidir_drive: cover property (@(posedge aclk) disable iff (!aresetn)
		(st.bidir & oe_line) != 8'h00);
	cov_regulated: cover property (@(posedge aclk) disable iff (!aresetn)
		(st.sio_reg & st.dm1) != 8'h00);

endmodule : iop_port

// ### iop_board.sv
// Board model: resolves each pin level from the port drivers and an external source.
`timescale 1ns/1ps
module iop_board (
	input wire logic aclk,
	input wire logic [7:0] pin_out,
	input wire logic [7:0] pin_strong_oe_n,
	input wire logic [7:0] pin_res_up,
	input wire logic [7:0] pin_res_down,
	input wire logic [7:0] ext_drive,
	input wire logic [7:0] ext_level,
	output logic [7:0] pin_in
);
	logic [7:0] float_pat = 8'h55;
	// A floating pin shows a changing pattern, never a steady level.
	always @(posedge aclk) begin
		float_pat <= ~float_pat;
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			if (!pin_strong_oe_n[i]) begin
				pin_in[i] = pin_out[i];
			end else if (ext_drive[i]) begin
				pin_in[i] = ext_level[i];
			end else if (pin_res_up[i]) begin
				pin_in[i] = 1'b1;
			end else if (pin_res_down[i]) begin
				pin_in[i] = 1'b0;
			end else begin
				pin_in[i] = float_pat[i];
			end
		end
	end
endmodule : iop_board

// ### io_pin_drive_and_interrupt_test.sv
// Self-checking bench for the eight-pin port block.
`timescale 1ns/1ps
module io_pin_drive_and_interrupt_test;
	import iop_pkg::*;
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'hf;
	logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0] s_axi_bresp, s_axi_rresp, pin_threshold_sel;
	logic [31:0] s_axi_rdata;
	logic [7:0] pin_in, pin_out, pin_strong_oe_n, pin_res_up, pin_res_down, pin_slow_slew;
	logic [7:0] pin_inbuf_en, pin_vhigh_regulated, sys_in;
	logic [7:0] sys_out = 8'h00, ext_drive = 8'hff, ext_level = 8'h3c;
	logic [15:0] aux_oe = 16'h0;
	logic pin_lvttl, pin_hyst_en, port_irq;
	int n_errors = 0, total_checks = 0;
	logic [2:0] m, e;
	logic d;
	logic [1:0] resp;
	logic [31:0] rv;
	always #10 aclk = ~aclk;
	iop_port dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr),
		.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
		.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
		.s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
		.s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
		.s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid),
		.s_axi_rready(s_axi_rready), .pin_in(pin_in), .pin_out(pin_out),
		.pin_strong_oe_n(pin_strong_oe_n), .pin_res_up(pin_res_up), .pin_res_down(pin_res_down),
		.pin_slow_slew(pin_slow_slew), .pin_inbuf_en(pin_inbuf_en),
		.pin_vhigh_regulated(pin_vhigh_regulated), .pin_lvttl(pin_lvttl),
		.pin_hyst_en(pin_hyst_en), .pin_threshold_sel(pin_threshold_sel), .sys_out(sys_out),
		.aux_oe(aux_oe), .sys_in(sys_in), .port_irq(port_irq));
	iop_board board_u (.aclk(aclk), .pin_out(pin_out), .pin_strong_oe_n(pin_strong_oe_n),
		.pin_res_up(pin_res_up), .pin_res_down(pin_res_down), .ext_drive(ext_drive),
		.ext_level(ext_level), .pin_in(pin_in));
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", total_checks, n_errors);
		if (n_errors == 0 && total_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask : tally_and_finish
	task automatic chk_v(input string nm, input logic [31:0] ev, input logic [31:0] g);
		total_checks++;
		if (g !== ev) begin
			$display("CHECK FAILED %s expected %h seen %h", nm, ev, g);
			n_errors++;
		end
	endtask : chk_v
	// Handshakes are judged at the falling edge, where the ready lines have settled.
	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, output logic [1:0] r);
		logic ta, tw, tb;
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_awvalid && s_axi_awready;
			tw = s_axi_wvalid && s_axi_wready;
			tb = s_axi_bvalid;
			r = s_axi_bresp;
			@(posedge aclk);
			if (ta) s_axi_awvalid <= 1'b0;
			if (tw) s_axi_wvalid <= 1'b0;
			n++;
		end while (tb !== 1'b1 && n < 100);
		s_axi_bready <= 1'b0;
		if (tb !== 1'b1) chk_v("bvalid", 1, tb);
		@(negedge aclk);
	endtask : axi_wr
	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] r);
		logic ta, tr;
		int n;
		n = 0;
		@(posedge aclk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(negedge aclk);
			ta = s_axi_arvalid && s_axi_arready;
			tr = s_axi_rvalid;
			v = s_axi_rdata;
			r = s_axi_rresp;
			@(posedge aclk);
			if (ta) s_axi_arvalid <= 1'b0;
			n++;
		end while (tr !== 1'b1 && n < 100);
		s_axi_rready <= 1'b0;
		if (tr !== 1'b1) chk_v("rvalid", 1, tr);
		@(negedge aclk);
	endtask : axi_rd
	task automatic wr(input logic [7:0] a, input logic [31:0] v);
		logic [1:0] r;
		axi_wr(a, v, r);
		chk_v("bresp", RESP_OKAY, r);
	endtask : wr
	task automatic chk_rd(input logic [7:0] a, input logic [31:0] ev);
		logic [31:0] v;
		logic [1:0] r;
		axi_rd(a, v, r);
		chk_v("rresp", RESP_OKAY, r);
		chk_v("rdata", ev, v);
	endtask : chk_rd
	task automatic set_mode(input logic [2:0] md);
		wr(OFS_DM0, {24'h0, {8{md[0]}}});
		wr(OFS_DM1, {24'h0, {8{md[1]}}});
		wr(OFS_DM2, {24'h0, {8{md[2]}}});
	endtask : set_mode
	// Returns strong, pull-up and pull-down enables for one mode and data state.
	function automatic logic [2:0] exp_drive(input logic [2:0] md, input logic dv);
		case (md)
			3'h2: return dv ? 3'b010 : 3'b100;
			3'h3: return dv ? 3'b100 : 3'b001;
			3'h4: return dv ? 3'b000 : 3'b100;
			3'h5: return dv ? 3'b100 : 3'b000;
			3'h6: return 3'b100;
			3'h7: return dv ? 3'b010 : 3'b001;
			default: return 3'b000;
		endcase
	endfunction : exp_drive
	initial begin
		#200000;
		n_errors++;
		tally_and_finish();
	end
	initial begin
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk_v("oe_n", 8'hff, pin_strong_oe_n);
		chk_v("res", 8'h00, pin_res_up | pin_res_down);
		chk_v("inbuf", 8'h00, pin_inbuf_en);
		chk_v("irq", 0, port_irq);
		chk_rd(OFS_DM0, 0);
		$display("test reset done");
		wr(OFS_SLEW, 32'hff);
		for (int i = 0; i < 16; i++) begin
			m = i[3:1];
			d = i[0];
			set_mode(m);
			wr(OFS_DATA, {24'h0, {8{d}}});
			e = exp_drive(m, d);
			chk_v("oe_n", {8{~e[2]}}, pin_strong_oe_n);
			chk_v("up", {8{e[1]}}, pin_res_up);
			chk_v("down", {8{e[0]}}, pin_res_down);
			chk_v("inbuf", {8{m != 3'h0}}, pin_inbuf_en);
			chk_v("slew", {8{(m >= 3'h4) && (m <= 3'h6)}}, pin_slow_slew);
			chk_v("pin_out", {8{d}}, pin_out);
		end
		$display("test drive_modes done");
		wr(OFS_DATA, 0);
		wr(OFS_SLEW, 0);
		wr(OFS_PIN_FORM + 8'h0c, 32'h2d);
		chk_rd(OFS_DATA, 32'h08);
		chk_rd(OFS_DM0, 32'hf7);
		chk_rd(OFS_SLEW, 32'h08);
		repeat (8) @(posedge aclk);
		chk_rd(OFS_PIN_FORM + 8'h0c, 32'h3d);
		$display("test pin_form done");
		set_mode(DM_HIZ_DIGITAL);
		repeat (8) @(posedge aclk);
		chk_rd(OFS_PIN_STATE, 32'h3c);
		chk_v("sys_in", 8'h3c, sys_in);
		wr(OFS_INBUF_DIS, 32'h0f);
		chk_v("inbuf", 8'hf0, pin_inbuf_en);
		repeat (8) @(posedge aclk);
		chk_rd(OFS_PIN_STATE, 32'h30);
		wr(OFS_INBUF_DIS, 0);
		$display("test input done");
		set_mode(DM_STRONG);
		@(posedge aclk);
		sys_out <= 8'ha5;
		wr(OFS_BYPASS, 32'h0f);
		chk_v("pin_out", 8'h05, pin_out);
		wr(OFS_BYPASS, 0);
		wr(OFS_BIDIR_EN, 32'h01);
		wr(OFS_OE_SEL_LO, 32'h0f);
		chk_v("oe_n", 8'h01, pin_strong_oe_n);
		@(posedge aclk);
		aux_oe <= 16'h8000;
		@(negedge aclk);
		chk_v("oe_n", 8'h00, pin_strong_oe_n);
		wr(OFS_BIDIR_EN, 0);
		$display("test bypass_bidir done");
		set_mode(DM_HIZ_DIGITAL);
		@(posedge aclk);
		ext_level <= 8'h00;
		repeat (8) @(posedge aclk);
		wr(OFS_INT_TYPE, 32'h39);
		chk_rd(OFS_INT_STAT, 0);
		@(posedge aclk);
		ext_level <= 8'h0f;
		repeat (8) @(posedge aclk);
		chk_v("irq", 1, port_irq);
		chk_rd(OFS_INT_STAT, 32'h05);
		chk_rd(OFS_INT_STAT, 0);
		chk_v("irq", 0, port_irq);
		@(posedge aclk);
		ext_level <= 8'h00;
		repeat (8) @(posedge aclk);
		wr(OFS_INT_STAT, 32'h02);
		chk_v("irq", 1, port_irq);
		chk_rd(OFS_INT_STAT, 32'h04);
		chk_v("irq", 0, port_irq);
		$display("test interrupts done");
		wr(OFS_PORT_CTL, 32'h0d);
		chk_v("ctl", 4'hd, {pin_threshold_sel, pin_hyst_en, pin_lvttl});
		wr(OFS_PORT_CTL, 32'h06);
		chk_v("ctl", 4'h6, {pin_threshold_sel, pin_hyst_en, pin_lvttl});
		wr(OFS_SIO_CFG, 32'h01);
		set_mode(DM_RES_UP);
		wr(OFS_DATA, 32'hff);
		chk_v("vhigh", 8'h01, pin_vhigh_regulated);
		chk_v("up", 8'hfe, pin_res_up);
		chk_v("oe_n", 8'hff, pin_strong_oe_n);
		$display("test special_pins done");
		axi_wr(8'h60, 32'h0, resp);
		chk_v("bresp", RESP_SLVERR, resp);
		axi_rd(8'h7c, rv, resp);
		chk_v("rresp", RESP_SLVERR, resp);
		chk_v("rdata", 0, rv);
		chk_rd(OFS_DATA, 32'hff);
		$display("test unmapped done");
		@(posedge aclk);
		aresetn <= 1'b0;
		repeat (3) @(posedge aclk);
		aresetn <= 1'b1;
		@(negedge aclk);
		chk_v("oe_n", 8'hff, pin_strong_oe_n);
		chk_v("res", 8'h00, pin_res_up | pin_res_down);
		chk_v("inbuf", 8'h00, pin_inbuf_en);
		chk_v("vhigh", 8'h00, pin_vhigh_regulated);
		chk_v("irq", 0, port_irq);
		chk_rd(OFS_SIO_CFG, 0);
		chk_rd(OFS_DATA, 0);
		$display("test mid_reset done");
		tally_and_finish();
	end
endmodule : io_pin_drive_and_interrupt_test
